// ### inc/elc_consts.svh
// register map, field positions, reset values and timing for the loop-code block
`ifndef ELC_CONSTS_SVH
`define ELC_CONSTS_SVH

// ----------------------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------------------
`define ELC_A_CTRL   4'h0
`define ELC_A_STAT   4'h4
`define ELC_A_MASK   4'h8
`define ELC_A_TEST   4'hc

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define ELC_B_SEL_HI 7
`define ELC_B_SEL_LO 6
`define ELC_B_CODE   5
`define ELC_B_BPV    2
`define ELC_B_BER    1
`define ELC_B_FLAG   3
`define ELC_B_LB     4
`define ELC_B_MODE   8

// ----------------------------------------------------------------------------
// codes and reset values
// ----------------------------------------------------------------------------
`define ELC_SEL_OFF  2'h0
`define ELC_SEL_UP   2'h1
`define ELC_SEL_DOWN 2'h2
`define ELC_SEL_AUTO 2'h3
`define ELC_QRSS_SEL 3'h4
`define ELC_CTRL_RST 8'h00
`define ELC_TEST_RST 3'h0
`define ELC_RESP_OK  2'h0
`define ELC_RESP_ERR 2'h2

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define ELC_HOLD_SEC 5
`define ELC_CLK_HZ   200000000

`endif

// ### inc/elc_pkg.sv
// types shared by the loop-code and error-insert block
`default_nettype none

package elc_pkg;

	// ------------------------------------------------------------------------
	// detector modes
	// ------------------------------------------------------------------------
	typedef enum logic [4:0] {
		ELC_OFF       = 5'h01,
		ELC_UP        = 5'h02,
		ELC_DOWN      = 5'h04,
		ELC_AUTO_UP   = 5'h08,
		ELC_AUTO_DOWN = 5'h10
	} elc_mode_t;

	// ------------------------------------------------------------------------
	// carriers and module states
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic pos;
		logic neg;
	} elc_rail_t;

	typedef struct packed {
		logic [2:0] clk_s;
		logic       bpv_q;
		logic       ber_q;
		logic       tick;
		logic       bpv_fire;
		logic       ber_fire;
	} elc_ins_t;

	typedef struct packed {
		logic [4:0]  hist;
		logic [2:0]  seen;
		logic        prev_down;
		logic [31:0] timer;
		logic        done;
		logic        hit;
	} elc_det_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        arready;
		logic        bvalid;
		logic        rvalid;
		logic [1:0]  bresp;
		logic [1:0]  rresp;
		logic [31:0] rdata;
		logic        aw_got;
		logic        w_got;
		logic [3:0]  waddr;
		logic [31:0] wdata;
		logic        wlane0;
		logic [7:0]  ctrl;
		logic        flag;
		logic        mask;
		logic [2:0]  test_sel;
		elc_mode_t   mode;
		logic        remote_lb;
		logic        irq;
		logic [2:0]  rclk;
		elc_rail_t   rx_s1;
		elc_rail_t   rx_s2;
		logic        rx_last;
		logic [2:0]  rx_win;
		logic        rx_data;
		logic        rx_valid;
		logic [1:0]  txi_s1;
		logic [1:0]  txi_s2;
		logic [3:0]  tx_d;
		logic [3:0]  tx_b;
		logic [3:0]  tx_v;
		logic        tx_last;
		logic        tx_par;
		logic        bpv_pend;
		elc_rail_t   tx_out;
	} elc_top_t;

endpackage : elc_pkg

`default_nettype wire

// ### hw/elc_loop_detect.sv
// repeating loop-up / loop-down code detector with hold timer
`include "elc_consts.svh"
`default_nettype none

module elc_loop_detect #(
	parameter int unsigned HOLD_CYCLES = `ELC_HOLD_SEC * `ELC_CLK_HZ
) (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic enable,
	input  wire logic want_down,
	input  wire logic bit_valid,
	input  wire logic bit_in,
	output logic      hit
);

	elc_pkg::elc_det_t r;
	elc_pkg::elc_det_t next_r;
	logic              in_pat;
	logic [2:0]        span;

	// exactly one mark among the lowest n bits of the window
	function automatic logic elc_one_mark(input logic [4:0] w,
		input logic [2:0] n);
		logic [2:0] c;
		c = 3'h0;
		for (int i = 0; i < 5; i++) begin
			if (i < int'(n))
				c = c + {2'h0, w[i]};
		end
		return c == 3'h1;
	endfunction : elc_one_mark

	always_comb begin
		next_r = r;
		next_r.hit = 1'b0;
		next_r.prev_down = want_down;
		span = want_down ? 3'h3 : 3'h5;
		in_pat = 1'b0;
		if (!enable || want_down != r.prev_down) begin
			next_r.hist = 5'h00;
			next_r.seen = 3'h0;
			next_r.timer = 32'h0;
			next_r.done = 1'b0;
		end else begin
			if (bit_valid) begin
				next_r.hist = {r.hist[3:0], bit_in};
				if (r.seen != 3'h5)
					next_r.seen = r.seen + 3'h1;
			end
			// sliding window of 00001 or 001 holds one mark everywhere
			in_pat = next_r.seen >= span &&
				elc_one_mark(next_r.hist, span);
			if (!in_pat) begin
				next_r.timer = 32'h0;
				next_r.done = 1'b0;
			end else if (!r.done) begin
				if (r.timer == 32'(HOLD_CYCLES)) begin
					next_r.hit = 1'b1;
					next_r.done = 1'b1;
				end else begin
					next_r.timer = r.timer + 32'h1;
				end
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			r <= '0;
		else
			r <= next_r;
	end

	assign hit = r.hit;

endmodule : elc_loop_detect

`default_nettype wire

// ### hw/elc_tx_insert.sv
// transmit clock edge finder and one-shot insertion triggers
`default_nettype none

module elc_tx_insert (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic chan_tx_clock,
	input  wire logic violation_insert_ctl,
	input  wire logic bit_error_insert_ctl,
	output logic      tick,
	output logic      bpv_fire,
	output logic      ber_fire
);

	elc_pkg::elc_ins_t r;
	elc_pkg::elc_ins_t next_r;
	logic              edge_seen;

	always_comb begin
		next_r = r;
		// two flops, then edge compare on the settled copies
		next_r.clk_s = {r.clk_s[1:0], chan_tx_clock};
		edge_seen = r.clk_s[1] & ~r.clk_s[2];
		next_r.tick = edge_seen;
		next_r.bpv_fire = 1'b0;
		next_r.ber_fire = 1'b0;
		if (edge_seen) begin
			// control bits are looked at only on transmit clock rises
			next_r.bpv_q = violation_insert_ctl;
			next_r.ber_q = bit_error_insert_ctl;
			next_r.bpv_fire = violation_insert_ctl & ~r.bpv_q;
			next_r.ber_fire = bit_error_insert_ctl & ~r.ber_q;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			r <= '0;
		else
			r <= next_r;
	end

	assign tick = r.tick;
	assign bpv_fire = r.bpv_fire;
	assign ber_fire = r.ber_fire;

endmodule : elc_tx_insert

`default_nettype wire

// ### hw/elc_line_ctrl.sv
// e1 channel loop-code detection, line coding and error insertion top
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite register port.
`include "elc_consts.svh"
`default_nettype none

module elc_line_ctrl #(
	parameter int unsigned HOLD_CYCLES = `ELC_HOLD_SEC * `ELC_CLK_HZ
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [3:0]        awaddr,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	input  wire logic [3:0]        araddr,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	input  wire logic              chan_rx_clock,
	input  wire elc_pkg::elc_rail_t rx_rail,
	input  wire logic              chan_tx_clock,
	input  wire logic              tx_data,
	input  wire logic              tx_test_data,
	output elc_pkg::elc_rail_t     tx_rail,
	output logic                   rx_data,
	output logic                   rx_valid,
	output logic                   remote_loopback,
	output logic                   irq
);

	elc_pkg::elc_top_t r;
	elc_pkg::elc_top_t next_r;
	logic              det_hit;
	logic              det_on;
	logic              det_down;
	logic              ins_tick;
	logic              bpv_fire;
	logic              ber_fire;
	logic              hdb3;
	logic              rx_edge;
	logic              rx_mark;
	logic              rx_viol;
	logic              tx_in;
	logic              mark;
	logic              ins;
	logic              viol;
	logic              pol;
	logic              par;
	logic [3:0]        d;
	logic [3:0]        b;
	logic [3:0]        v;
	logic              flag_set;

	function automatic logic elc_mapped(input logic [3:0] a);
		return a == `ELC_A_CTRL || a == `ELC_A_STAT ||
			a == `ELC_A_MASK || a == `ELC_A_TEST;
	endfunction : elc_mapped

	// ------------------------------------------------------------------------
	// sub blocks
	// ------------------------------------------------------------------------
	elc_loop_detect #(
		.HOLD_CYCLES(HOLD_CYCLES)
	) u_det (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.enable    (det_on),
		.want_down (det_down),
		.bit_valid (r.rx_valid),
		.bit_in    (r.rx_data),
		.hit       (det_hit)
	);

	elc_tx_insert u_ins (
		.aclk                 (aclk),
		.aresetn              (aresetn),
		.chan_tx_clock        (chan_tx_clock),
		.violation_insert_ctl (r.ctrl[`ELC_B_BPV]),
		.bit_error_insert_ctl (r.ctrl[`ELC_B_BER]),
		.tick                 (ins_tick),
		.bpv_fire             (bpv_fire),
		.ber_fire             (ber_fire)
	);

	assign det_on = r.mode != elc_pkg::ELC_OFF;
	assign det_down = r.mode == elc_pkg::ELC_DOWN ||
		r.mode == elc_pkg::ELC_AUTO_DOWN;

	// ------------------------------------------------------------------------
	// next state
	// ------------------------------------------------------------------------
	always_comb begin
		next_r = r;
		flag_set = 1'b0;
		rx_mark = 1'b0;
		rx_viol = 1'b0;
		tx_in = 1'b0;
		mark = 1'b0;
		ins = 1'b0;
		viol = 1'b0;
		pol = 1'b0;
		par = 1'b0;
		d = r.tx_d;
		b = r.tx_b;
		v = r.tx_v;
		hdb3 = ~r.ctrl[`ELC_B_CODE];

		// receive side: sync pins, decode one bit per rx clock rise
		next_r.rclk = {r.rclk[1:0], chan_rx_clock};
		next_r.rx_s1 = rx_rail;
		next_r.rx_s2 = r.rx_s1;
		rx_edge = r.rclk[1] & ~r.rclk[2];
		next_r.rx_valid = 1'b0;
		if (rx_edge) begin
			rx_mark = r.rx_s2.pos | r.rx_s2.neg;
			// a same-polarity mark closes a 000v or b00v group
			rx_viol = hdb3 && rx_mark &&
				r.rx_s2.pos == r.rx_last;
			next_r.rx_data = rx_viol ? 1'b0 : r.rx_win[2];
			next_r.rx_valid = 1'b1;
			next_r.rx_win = rx_viol ? 3'h0 : {r.rx_win[1:0], rx_mark};
			if (rx_mark)
				next_r.rx_last = r.rx_s2.pos;
		end

		// transmit side: four-bit window for zero substitution
		next_r.txi_s1 = {tx_test_data, tx_data};
		next_r.txi_s2 = r.txi_s1;
		if (ins_tick) begin
			if (r.test_sel == `ELC_QRSS_SEL)
				tx_in = r.txi_s2[1] ^ ber_fire;
			else
				tx_in = r.txi_s2[0];
			mark = r.tx_d[3] | r.tx_b[3] | r.tx_v[3];
			// pending violation lands on the next ordinary mark
			ins = r.bpv_pend & mark & ~r.tx_v[3];
			viol = r.tx_v[3] | ins;
			pol = viol ? r.tx_last : ~r.tx_last;
			next_r.tx_out.pos = mark & pol;
			next_r.tx_out.neg = mark & ~pol;
			if (mark)
				next_r.tx_last = pol;
			if (ins)
				next_r.bpv_pend = 1'b0;
			par = r.tx_v[3] ? 1'b0 : r.tx_par ^ mark;
			next_r.tx_par = par;
			d = {r.tx_d[2:0], tx_in};
			b = {r.tx_b[2:0], 1'b0};
			v = {r.tx_v[2:0], 1'b0};
			if (hdb3 && d == 4'h0 && b == 4'h0 && v == 4'h0) begin
				v[0] = 1'b1;
				if (!par)
					b[3] = 1'b1;
			end
			next_r.tx_d = d;
			next_r.tx_b = b;
			next_r.tx_v = v;
		end
		if (bpv_fire)
			next_r.bpv_pend = 1'b1;

		// loop-code mode sequencing
		case (r.mode)
		elc_pkg::ELC_OFF: begin
		end
		elc_pkg::ELC_UP, elc_pkg::ELC_DOWN: begin
			if (det_hit)
				flag_set = 1'b1;
		end
		elc_pkg::ELC_AUTO_UP: begin
			if (det_hit) begin
				flag_set = 1'b1;
				next_r.remote_lb = 1'b1;
				next_r.mode = elc_pkg::ELC_AUTO_DOWN;
			end
		end
		elc_pkg::ELC_AUTO_DOWN: begin
			if (det_hit) begin
				flag_set = 1'b1;
				next_r.remote_lb = 1'b0;
				next_r.mode = elc_pkg::ELC_OFF;
			end
		end
		default: begin
			next_r.mode = elc_pkg::ELC_OFF;
		end
		endcase

		// bus write channels, taken in either order
		if (awvalid && r.awready) begin
			next_r.aw_got = 1'b1;
			next_r.waddr = awaddr;
		end
		if (wvalid && r.wready) begin
			next_r.w_got = 1'b1;
			next_r.wdata = wdata;
			next_r.wlane0 = wstrb[0];
		end
		if (r.bvalid && bready)
			next_r.bvalid = 1'b0;
		if (r.aw_got && r.w_got) begin
			next_r.aw_got = 1'b0;
			next_r.w_got = 1'b0;
			next_r.bvalid = 1'b1;
			next_r.bresp = elc_mapped(r.waddr) ?
				`ELC_RESP_OK : `ELC_RESP_ERR;
			if (r.wlane0) begin
				case (r.waddr)
				`ELC_A_CTRL: begin
					next_r.ctrl = r.wdata[7:0];
					// only a new select value restarts the sequencer
					if (r.wdata[`ELC_B_SEL_HI:`ELC_B_SEL_LO] !=
						r.ctrl[`ELC_B_SEL_HI:`ELC_B_SEL_LO]) begin
						next_r.remote_lb = 1'b0;
						case (r.wdata[`ELC_B_SEL_HI:`ELC_B_SEL_LO])
						`ELC_SEL_UP: next_r.mode = elc_pkg::ELC_UP;
						`ELC_SEL_DOWN: next_r.mode = elc_pkg::ELC_DOWN;
						`ELC_SEL_AUTO: next_r.mode = elc_pkg::ELC_AUTO_UP;
						default: next_r.mode = elc_pkg::ELC_OFF;
						endcase
					end
				end
				`ELC_A_STAT: begin
					if (r.wdata[`ELC_B_FLAG])
						next_r.flag = 1'b0;
				end
				`ELC_A_MASK: next_r.mask = r.wdata[`ELC_B_FLAG];
				`ELC_A_TEST: next_r.test_sel = r.wdata[2:0];
				default: begin
				end
				endcase
			end
		end
		// a detection in the clearing cycle is kept
		if (flag_set)
			next_r.flag = 1'b1;

		// bus read channel
		if (r.rvalid && rready)
			next_r.rvalid = 1'b0;
		if (arvalid && r.arready) begin
			next_r.rvalid = 1'b1;
			next_r.rresp = elc_mapped(araddr) ?
				`ELC_RESP_OK : `ELC_RESP_ERR;
			next_r.rdata = 32'h0;
			case (araddr)
			`ELC_A_CTRL: next_r.rdata[7:0] = r.ctrl;
			`ELC_A_STAT: next_r.rdata[`ELC_B_FLAG] = r.flag;
			`ELC_A_MASK: next_r.rdata[`ELC_B_FLAG] = r.mask;
			`ELC_A_TEST: begin
				next_r.rdata[2:0] = r.test_sel;
				next_r.rdata[`ELC_B_LB] = r.remote_lb;
				next_r.rdata[`ELC_B_MODE +: 5] = r.mode;
			end
			default: begin
			end
			endcase
		end

		next_r.irq = next_r.flag & next_r.mask;
		next_r.awready = !next_r.aw_got && !next_r.bvalid;
		next_r.wready = !next_r.w_got && !next_r.bvalid;
		next_r.arready = !next_r.rvalid;
	end

	// ------------------------------------------------------------------------
	// state register
	// ------------------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			r <= '0;
			r.mode <= elc_pkg::ELC_OFF;
			r.ctrl <= `ELC_CTRL_RST;
			r.test_sel <= `ELC_TEST_RST;
		end else begin
			r <= next_r;
		end
	end

	assign awready = r.awready;
	assign wready = r.wready;
	assign bresp = r.bresp;
	assign bvalid = r.bvalid;
	assign arready = r.arready;
	assign rdata = r.rdata;
	assign rresp = r.rresp;
	assign rvalid = r.rvalid;
	assign tx_rail = r.tx_out;
	assign rx_data = r.rx_data;
	assign rx_valid = r.rx_valid;
	assign remote_loopback = r.remote_lb;
	assign irq = r.irq;

endmodule : elc_line_ctrl

`default_nettype wire

// ### tb/elc_line_ctrl_asserts.sv
// concurrent checks on the loop-code block ports
`default_nettype none

module elc_line_ctrl_asserts (
	input wire logic               aclk,
	input wire logic               aresetn,
	input wire logic               awvalid,
	input wire logic               awready,
	input wire logic               wvalid,
	input wire logic               wready,
	input wire logic [1:0]         bresp,
	input wire logic               bvalid,
	input wire logic               bready,
	input wire logic               arvalid,
	input wire logic               arready,
	input wire logic [31:0]        rdata,
	input wire logic               rvalid,
	input wire logic               rready,
	input wire logic               chan_rx_clock,
	input wire logic               chan_tx_clock,
	input wire elc_pkg::elc_rail_t tx_rail,
	input wire logic               rx_data,
	input wire logic               rx_valid,
	input wire logic               remote_loopback,
	input wire logic               irq
);
	timeunit 1ns;
	timeprecision 1ps;

	// ------------------------------------------------------------------
	// bus handshakes
	// ------------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	wr_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write answer not held");
	rd_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read answer not held");
	wr_busy_a: assert property (bvalid |-> !awready && !wready)
		else $error("write taken while answer pending");
	rd_busy_a: assert property (rvalid |-> !arready)
		else $error("read taken while answer pending");
	rd_lat_a: assert property (arvalid && arready |=> rvalid)
		else $error("read answer late");
	wr_lat_a: assert property (awvalid && awready && wvalid && wready
		|-> ##2 bvalid) else $error("write answer late");

	// ------------------------------------------------------------------
	// line timing
	// ------------------------------------------------------------------
	rx_lat_a: assert property ($rose(chan_rx_clock) |-> ##[3:5] rx_valid)
		else $error("receive bit late");
	rx_pulse_a: assert property (rx_valid |=> !rx_valid [*8])
		else $error("receive strobe too long");
	rx_data_a: assert property ($changed(rx_data) |-> rx_valid)
		else $error("receive data moved off strobe");
	tx_tick_a: assert property ($changed(tx_rail) |-> $past(chan_tx_clock, 2))
		else $error("transmit marks moved off tick");

	cover property ($rose(remote_loopback));
	cover property ($rose(irq));
	cover property (bvalid && bresp == 2'h2);
endmodule : elc_line_ctrl_asserts

`default_nettype wire

// ### tb/elc_line_model.sv
// far-end line: free running clocks, loop code marks, transmit data
`default_nettype none

module elc_line_model (
	input  wire logic [1:0]    rx_pat,
	input  wire logic          tx_level,
	output logic               chan_rx_clock,
	output elc_pkg::elc_rail_t rx_rail,
	output logic               chan_tx_clock,
	output logic               tx_data,
	output logic               tx_test_data
);
	timeunit 1ns;
	timeprecision 1ps;

	int   idx = 0;
	logic pol = 1'b0;
	logic mark;

	initial chan_rx_clock = 1'b0;
	initial chan_tx_clock = 1'b0;
	initial rx_rail = '0;
	always #40.007 chan_rx_clock = ~chan_rx_clock;
	always #43.001 chan_tx_clock = ~chan_tx_clock;
	assign tx_data = tx_level;
	assign tx_test_data = tx_level;

	// pattern 0: all marks, 1: 00001 repeating, 2: 001 repeating
	assign mark = (rx_pat == 2'h0) || (idx == ((rx_pat == 2'h1) ? 4 : 2));
	always @(negedge chan_rx_clock) begin
		rx_rail <= '{pos: mark & pol, neg: mark & ~pol};
		pol <= pol ^ mark;
		idx <= (idx >= ((rx_pat == 2'h1) ? 4 : 2)) ? 0 : idx + 1;
	end
endmodule : elc_line_model

`default_nettype wire

// ### tb/testbench.sv
// self-checking bench for the loop-code and error-insert block
`include "elc_consts.svh"
`default_nettype none

module testbench;
	timeunit 1ns;
	timeprecision 1ps;

	logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
	logic bready = 1'b0, arvalid = 1'b0, rready = 1'b0, tx_level = 1'b0;
	logic [3:0]  awaddr = '0, araddr = '0;
	logic [31:0] wdata = '0;
	logic [1:0]  rx_pat = '0;
	logic awready, wready, bvalid, arready, rvalid, rx_data, rx_valid;
	logic remote_loopback, irq, chan_rx_clock, chan_tx_clock;
	logic tx_data, tx_test_data;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	elc_pkg::elc_rail_t rx_rail, tx_rail, last_mark = '0;
	logic [33:0] bq[$], rq[$];
	int failures = 0, n_checks = 0, seed = 72, d;
	int mark_n, zero_n, bpv_n;
	logic [4:0]  rx_hist = '0;

	always #2.5 aclk = ~aclk;

	elc_line_ctrl #(.HOLD_CYCLES(100)) uut (.aclk, .aresetn, .awaddr,
		.awvalid, .awready, .wdata, .wstrb(4'hf), .wvalid, .wready, .bresp,
		.bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
		.rvalid, .rready, .chan_rx_clock, .rx_rail, .chan_tx_clock,
		.tx_data, .tx_test_data, .tx_rail, .rx_data, .rx_valid,
		.remote_loopback, .irq);
	elc_line_model line (.rx_pat, .tx_level, .chan_rx_clock, .rx_rail,
		.chan_tx_clock, .tx_data, .tx_test_data);

	// ------------------------------------------------------------------
	// checking and closing
	// ------------------------------------------------------------------
	task automatic cmp(input string nm, input logic [33:0] e,
			input logic [33:0] s);
		n_checks++;
		if (s !== e) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask : cmp

	task automatic close_out;
		if (failures == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : close_out

	task automatic give_up;
		failures++;
		close_out();
	endtask : give_up

	always @(posedge aclk) begin
		if (bvalid && bready) cmp("bresp", bq.pop_front(), 34'(bresp));
		if (rvalid && rready) cmp("rdata", rq.pop_front(), {rresp, rdata});
		if (rx_valid) rx_hist <= {rx_hist[3:0], rx_data};
	end

	always @(posedge chan_tx_clock) begin
		if (tx_rail.pos || tx_rail.neg) begin
			if (tx_rail === last_mark) bpv_n++;
			last_mark = tx_rail;
			mark_n++;
		end else begin
			zero_n++;
		end
	end

	// ------------------------------------------------------------------
	// bus and wait tasks
	// ------------------------------------------------------------------
	task automatic wr(input logic [3:0] a, input int v, input logic [1:0] e);
		int n;
		n = 0;
		@(posedge aclk);
		bq.push_back({32'h0, e});
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid && n < 50);
		bready <= 1'b0;
		if (n >= 50) give_up();
	endtask : wr

	task automatic rd(input logic [3:0] a, input logic [33:0] e);
		int n;
		n = 0;
		@(posedge aclk);
		rq.push_back(e);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (arready) arvalid <= 1'b0;
		end while (!rvalid && n < 50);
		rready <= 1'b0;
		if (n >= 50) give_up();
	endtask : rd

	task automatic wt(input int s, input logic v);
		int n;
		n = 0;
		while (((s == 0) ? irq : remote_loopback) !== v && n < 3000) begin
			@(posedge aclk);
			n++;
		end
		if (n >= 3000) give_up();
	endtask : wt

	task automatic ticks(input int k);
		repeat (k) @(posedge chan_tx_clock);
		@(negedge chan_tx_clock);
	endtask : ticks

	task automatic tx_clr;
		ticks(6);
		mark_n = 0;
		zero_n = 0;
		bpv_n = 0;
	endtask : tx_clr

	task automatic wrt(input int v);
		wr(`ELC_A_CTRL, v, `ELC_RESP_OK);
		ticks(2);
	endtask : wrt

	// ------------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------------
	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		rd(`ELC_A_CTRL, 34'h0);
		rd(`ELC_A_STAT, 34'h0);
		rd(`ELC_A_MASK, 34'h0);
		rd(`ELC_A_TEST, 34'h100);
		d = $random(seed) & 32'h39;
		wr(`ELC_A_CTRL, d, `ELC_RESP_OK);
		rd(`ELC_A_CTRL, 34'(d));
		wr(4'h2, 32'hff, `ELC_RESP_ERR);
		rd(4'h2, {`ELC_RESP_ERR, 32'h0});
		rx_pat <= 2'h1;
		wr(`ELC_A_CTRL, 32'h0, `ELC_RESP_OK);
		repeat (400) @(posedge aclk);
		rd(`ELC_A_STAT, 34'h0);
		wr(`ELC_A_CTRL, 32'h40, `ELC_RESP_OK);
		repeat (60) @(posedge aclk);
		rd(`ELC_A_STAT, 34'h0);
		repeat (340) @(posedge aclk);
		cmp("irq", 34'h0, 34'(irq));
		rd(`ELC_A_STAT, 34'h8);
		cmp("up code", 34'h1, 34'($countones(rx_hist)));
		wr(`ELC_A_MASK, 32'h8, `ELC_RESP_OK);
		wt(0, 1'b1);
		wr(`ELC_A_STAT, 32'h8, `ELC_RESP_OK);
		rd(`ELC_A_STAT, 34'h0);
		wt(0, 1'b0);
		rx_pat <= 2'h2;
		wr(`ELC_A_CTRL, 32'h80, `ELC_RESP_OK);
		wt(0, 1'b1);
		cmp("down code", 34'h1, 34'($countones(rx_hist[2:0])));
		rx_pat <= 2'h1;
		wr(`ELC_A_CTRL, 32'hc0, `ELC_RESP_OK);
		wt(1, 1'b1);
		rd(`ELC_A_TEST, 34'h1010);
		repeat (300) @(posedge aclk);
		rd(`ELC_A_TEST, 34'h1010);
		rx_pat <= 2'h2;
		wt(1, 1'b0);
		rd(`ELC_A_TEST, 34'h100);
		wrt(32'h0);
		tx_clr();
		ticks(12);
		cmp("hdb3 marks", 34'h1, 34'(mark_n != 0));
		cmp("hdb3 violations", 34'h1, 34'(bpv_n != 0));
		wrt(32'h20);
		tx_clr();
		ticks(12);
		cmp("ami marks", 34'h0, 34'(mark_n));
		tx_level <= 1'b1;
		for (int i = 0; i < 2; i++) begin
			wr(`ELC_A_TEST, 32'(i * 4), `ELC_RESP_OK);
			tx_clr();
			wrt(32'h24);
			wrt(32'h24);
			wrt(32'h22);
			ticks(8);
			cmp("violations", 34'h1, 34'(bpv_n));
			cmp("bit errors", 34'(i), 34'(zero_n));
			wrt(32'h20);
		end
		close_out();
	end
endmodule : testbench

bind elc_line_ctrl elc_line_ctrl_asserts chk (.aclk, .aresetn, .awvalid,
	.awready, .wvalid, .wready, .bresp, .bvalid, .bready, .arvalid,
	.arready, .rdata, .rvalid, .rready, .chan_rx_clock, .chan_tx_clock,
	.tx_rail, .rx_data, .rx_valid, .remote_loopback, .irq);

`default_nettype wire
